// ==== hdl/cpe_pkg.sv ====
`default_nettype none
package cpe_pkg;
  // ------------------------------------------------------------
  // register map (word index on the link)
  // ------------------------------------------------------------
  localparam logic [7:0]  REG_CONFIG  = 8'h00;
  localparam logic [7:0]  REG_SHUNT   = 8'h01;
  localparam logic [7:0]  REG_BUS     = 8'h02;
  localparam logic [7:0]  REG_POWER   = 8'h03;
  localparam logic [7:0]  REG_CURRENT = 8'h04;
  localparam logic [7:0]  REG_CAL     = 8'h05;

  // ------------------------------------------------------------
  // configuration word layout and power-up value
  // ------------------------------------------------------------
  localparam logic [15:0] CONFIG_RST  = 16'h399F;
  localparam int          CFG_RST_BIT = 15;
  localparam int          BRNG_BIT    = 13;
  localparam int          PG_LSB      = 11;
  localparam int          BADC_LSB    = 7;
  localparam int          SADC_LSB    = 3;
  localparam int          MODE_LSB    = 0;
  localparam logic [2:0]  MODE_PDOWN  = 3'h0;
  localparam logic [2:0]  MODE_ADCOFF = 3'h4;

  // ------------------------------------------------------------
  // bus voltage word layout, measurement and result scaling
  // ------------------------------------------------------------
  localparam int          BUS_SHIFT   = 3;
  localparam int          CONVERSION_READY_FLAG_BIT    = 1;
  localparam int          OVF_BIT     = 0;
  localparam int          SHUNT_LSB_UV   = 10;
  localparam int          BUS_LSB_MV     = 4;
  localparam int          PWR_LSB_RATIO  = 20;
  localparam logic signed [33:0] CUR_DIV = 34'sh0_0000_1000;
  localparam logic signed [33:0] PWR_DIV = 34'sh0_0000_1388;
  localparam logic [15:0] ZERO16      = 16'h0000;

  // ------------------------------------------------------------
  // calculation sequencer states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {CPE_IDLE, CPE_CUR, CPE_PWR, CPE_DONE} cpe_state_t;

  // host side sequencer states
  typedef enum logic [1:0] {CPH_INIT, CPH_IDLE, CPH_BUSY} cph_state_t;

  // clamp a wide quotient to the signed 16-bit result range
  function automatic logic [16:0] cpe_sat16(input logic signed [33:0] v);
    logic [16:0] r;
    r = {1'b0, v[15:0]};
    if (v > 34'sh0_0000_7FFF) begin
      r = {1'b1, 16'h7FFF};
    end else if (v < -34'sh0_0000_8000) begin
      r = {1'b1, 16'h8000};
    end
    return r;
  endfunction : cpe_sat16
endpackage : cpe_pkg
`default_nettype wire

// ==== hdl/cpe_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// register access link between host controller and monitor
interface cpe_link_if;
  logic        req;    // host request, held until ack
  logic        we;     // 1 = write
  logic [7:0]  addr;   // register index
  logic [15:0] wdata;  // write data
  logic        ack;    // one-cycle answer from device
  logic [15:0] rdata;  // read data, valid with ack
  modport dev  (input req, we, addr, wdata, output ack, rdata);
  modport host (output req, we, addr, wdata, input ack, rdata);
endinterface : cpe_link_if
`default_nettype wire

// ==== hdl/cpe_scale.sv ====
`timescale 1ns/1ps
`default_nettype none
// signed multiply then divide by a constant, saturated, one cycle
module cpe_scale
  import cpe_pkg::*;
(
  input  wire logic               clk_i,   // system clock
  input  wire logic               rst_i,   // async reset, high
  input  wire logic signed [15:0] a_i,     // signed operand
  input  wire logic        [15:0] b_i,     // unsigned operand
  input  wire logic               pwr_i,   // 1 = divide by power divisor
  output logic signed      [15:0] q_o,     // saturated quotient
  output logic                    ovf_o    // quotient was clamped
);
  import cpe_pkg::*;

  logic signed [33:0] prod_w;
  logic signed [33:0] quot_w;
  logic        [16:0] sat_w;
  logic signed [15:0] q_d;
  logic               ovf_d;

  // ------------------------------------------------------------
  // arithmetic
  // ------------------------------------------------------------
  // signed divide truncates toward zero, so reverse current mirrors forward current
  always_comb begin
    prod_w = 34'(a_i) * 34'($signed({1'b0, b_i}));
    quot_w = prod_w / (pwr_i ? PWR_DIV : CUR_DIV);
    sat_w  = cpe_sat16(quot_w);
    q_d    = $signed(sat_w[15:0]);
    ovf_d  = sat_w[16];
  end

  // registered result
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_o   <= '0;
      ovf_o <= 1'b0;
    end else begin
      q_o   <= q_d;
      ovf_o <= ovf_d;
    end
  end
endmodule : cpe_scale
`default_nettype wire

// ==== hdl/cpe_device.sv ====
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - results stay zero until calibration programmed
// - each new measurement pair refreshes results
// - current = shunt times cal over 4096
// - power = current times bus over 5000
// - bus value stored shifted left three bits
// - shunt count weighs ten microvolts
// - power count weighs twenty current counts
// - host computes cal from step and shunt
// - host picks step near max current/2^15
// - host may rescale cal for system error
// - power-up configuration: 12-bit, /8, 32V, continuous
// - all registers default at power-up; host rewrites
// - separate resolution/averaging for shunt and bus
// - ready flag only after multiplications finish
// - calculation never delays measurement capture
module cpe_device
  import cpe_pkg::*;
(
  input  wire logic               clk_i,           // system clock
  input  wire logic               rst_i,           // async reset, high
  cpe_link_if.dev                 link,            // register link
  input  wire logic               meas_valid_i,    // new shunt/bus pair
  input  wire logic signed [15:0] shunt_raw_i,     // shunt, 10 uV count
  input  wire logic        [12:0] bus_raw_i,       // bus, 4 mV count
  output logic             [3:0]  shunt_adc_o,     // shunt resolution/avg
  output logic             [3:0]  bus_adc_o,       // bus resolution/avg
  output logic             [1:0]  shunt_gain_range_o, // shunt gain
  output logic                    bus_range_o,     // 1 = 32 V range
  output logic             [2:0]  mode_o,          // conversion mode
  output logic                    conversion_ready_flag_o, // results ready
  output logic signed      [15:0] current_o,       // current result
  output logic signed      [15:0] power_o          // power result
);
  import cpe_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  cpe_state_t         st_q,    st_d;
  logic [15:0]        cfg_q,   cfg_d;
  logic [15:0]        cal_q,   cal_d;
  logic               calp_q,  calp_d;
  logic signed [15:0] shunt_q, shunt_d;
  logic [12:0]        busv_q,  busv_d;
  logic               conversion_ready_flag_q,  conversion_ready_flag_d;
  logic               ovf_q,   ovf_d;
  logic signed [15:0] cur_q,   cur_d;
  logic signed [15:0] pwr_q,   pwr_d;
  logic               ack_q,   ack_d;
  logic [15:0]        rdat_q,  rdat_d;

  logic               wr_w;
  logic               rd_w;
  logic signed [15:0] sc_a_w;
  logic        [15:0] sc_b_w;
  logic               sc_pwr_w;
  logic signed [15:0] sc_q_w;
  logic               sc_ovf_w;

  // ------------------------------------------------------------
  // shared scaler
  // ------------------------------------------------------------
  // one multiplier serves both products; power waits on current
  always_comb begin
    sc_a_w   = shunt_q;
    sc_b_w   = cal_q;
    sc_pwr_w = 1'b0;
    if (st_q == CPE_PWR) begin
      sc_a_w   = sc_q_w;
      sc_b_w   = {3'h0, busv_q};
      sc_pwr_w = 1'b1;
    end
  end

  cpe_scale u_scale (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .a_i   (sc_a_w),
    .b_i   (sc_b_w),
    .pwr_i (sc_pwr_w),
    .q_o   (sc_q_w),
    .ovf_o (sc_ovf_w)
  );

  // ------------------------------------------------------------
  // link access
  // ------------------------------------------------------------
  // ack is a single pulse; a request still held after ack is served again
  always_comb begin
    wr_w  = link.req && !ack_q && link.we;
    rd_w  = link.req && !ack_q && !link.we;
    ack_d = link.req && !ack_q;
    rdat_d = rdat_q;
    if (rd_w) begin
      case (link.addr)
        REG_CONFIG:  rdat_d = cfg_q;
        REG_SHUNT:   rdat_d = shunt_q;
        REG_BUS:     rdat_d = {busv_q, 1'b0, conversion_ready_flag_q, ovf_q};
        REG_POWER:   rdat_d = pwr_q;
        REG_CURRENT: rdat_d = cur_q;
        REG_CAL:     rdat_d = cal_q;
        default:     rdat_d = ZERO16;
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers and calculation sequencer
  // ------------------------------------------------------------
  always_comb begin
    st_d    = st_q;
    cfg_d   = cfg_q;
    cal_d   = cal_q;
    calp_d  = calp_q;
    shunt_d = shunt_q;
    busv_d  = busv_q;
    conversion_ready_flag_d  = conversion_ready_flag_q;
    ovf_d   = ovf_q;
    cur_d   = cur_q;
    pwr_d   = pwr_q;

    // software side first, so hardware events below win
    if (rd_w && link.addr == REG_BUS) begin
      conversion_ready_flag_d = 1'b0;
    end
    if (wr_w && link.addr == REG_CONFIG) begin
      cfg_d = link.wdata;
      if (link.wdata[MODE_LSB +: 3] != MODE_PDOWN &&
          link.wdata[MODE_LSB +: 3] != MODE_ADCOFF) begin
        conversion_ready_flag_d = 1'b0;
      end
      if (link.wdata[CFG_RST_BIT]) begin
        // software reset: power-up defaults, except shunt and bus words keep their values
        cfg_d  = CONFIG_RST;
        cal_d  = ZERO16;
        calp_d = 1'b0;
        conversion_ready_flag_d = 1'b0;
        ovf_d  = 1'b0;
        st_d   = CPE_IDLE;
      end
    end
    if (wr_w && link.addr == REG_CAL) begin
      cal_d  = link.wdata;
      calp_d = (link.wdata != ZERO16);
    end

    // measurement capture is never held off by the sequencer
    case (st_q)
      CPE_IDLE: begin
      end
      CPE_CUR: begin
        st_d = CPE_PWR;
      end
      CPE_PWR: begin
        cur_d = sc_q_w;
        ovf_d = sc_ovf_w;
        st_d  = CPE_DONE;
      end
      CPE_DONE: begin
        pwr_d  = sc_q_w;
        ovf_d  = ovf_q | sc_ovf_w;
        conversion_ready_flag_d = 1'b1;
        st_d   = CPE_IDLE;
      end
      default: begin
        st_d = CPE_IDLE;
      end
    endcase

    if (meas_valid_i) begin
      shunt_d = shunt_raw_i;
      busv_d  = bus_raw_i;
      st_d    = CPE_CUR;
    end

    if (!calp_d) begin
      cur_d = '0;
      pwr_d = '0;
    end
  end

  // all registers volatile: defaults on every reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q    <= CPE_IDLE;
      cfg_q   <= CONFIG_RST;
      cal_q   <= ZERO16;
      calp_q  <= 1'b0;
      shunt_q <= '0;
      busv_q  <= '0;
      conversion_ready_flag_q  <= 1'b0;
      ovf_q   <= 1'b0;
      cur_q   <= '0;
      pwr_q   <= '0;
      ack_q   <= 1'b0;
      rdat_q  <= ZERO16;
    end else begin
      st_q    <= st_d;
      cfg_q   <= cfg_d;
      cal_q   <= cal_d;
      calp_q  <= calp_d;
      shunt_q <= shunt_d;
      busv_q  <= busv_d;
      conversion_ready_flag_q  <= conversion_ready_flag_d;
      ovf_q   <= ovf_d;
      cur_q   <= cur_d;
      pwr_q   <= pwr_d;
      ack_q   <= ack_d;
      rdat_q  <= rdat_d;
    end
  end

  // ------------------------------------------------------------
  // outputs, all straight from flops
  // ------------------------------------------------------------
  assign link.ack                = ack_q;
  assign link.rdata              = rdat_q;
  assign shunt_adc_o             = cfg_q[SADC_LSB +: 4];
  assign bus_adc_o               = cfg_q[BADC_LSB +: 4];
  assign shunt_gain_range_o      = cfg_q[PG_LSB +: 2];
  assign bus_range_o             = cfg_q[BRNG_BIT];
  assign mode_o                  = cfg_q[MODE_LSB +: 3];
  assign conversion_ready_flag_o = conversion_ready_flag_q;
  assign current_o               = cur_q;
  assign power_o                 = pwr_q;
endmodule : cpe_device
`default_nettype wire

// ==== hdl/cpe_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// host controller end: restores calibration, then relays commands
module cpe_host
  import cpe_pkg::*;
(
  input  wire logic        clk_i,        // system clock
  input  wire logic        rst_i,        // async reset, high
  cpe_link_if.host         link,         // register link
  input  wire logic [15:0] cal_i,        // calibration to restore
  input  wire logic        cmd_valid_i,  // command request
  input  wire logic        cmd_write_i,  // 1 = write
  input  wire logic [7:0]  cmd_addr_i,   // register index
  input  wire logic [15:0] cmd_wdata_i,  // write data
  output logic             cmd_ready_o,  // command accepted when high
  output logic             rsp_valid_o,  // one-cycle completion
  output logic [15:0]      rsp_data_o    // read data
);
  import cpe_pkg::*;

  cph_state_t  st_q,   st_d;
  logic        req_q,  req_d;
  logic        we_q,   we_d;
  logic [7:0]  addr_q, addr_d;
  logic [15:0] wdat_q, wdat_d;
  logic        init_q, init_d;
  logic        rdy_q,  rdy_d;
  logic        rv_q,   rv_d;
  logic [15:0] rd_q,   rd_d;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  // device forgets calibration at power-up, so it is rewritten first
  always_comb begin
    st_d   = st_q;
    req_d  = req_q;
    we_d   = we_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    init_d = init_q;
    rdy_d  = rdy_q;
    rv_d   = 1'b0;
    rd_d   = rd_q;
    case (st_q)
      CPH_INIT: begin
        req_d  = 1'b1;
        we_d   = 1'b1;
        addr_d = REG_CAL;
        wdat_d = cal_i;
        init_d = 1'b1;
        st_d   = CPH_BUSY;
      end
      CPH_IDLE: begin
        if (cmd_valid_i && rdy_q) begin
          req_d  = 1'b1;
          we_d   = cmd_write_i;
          addr_d = cmd_addr_i;
          wdat_d = cmd_wdata_i;
          init_d = 1'b0;
          rdy_d  = 1'b0;
          st_d   = CPH_BUSY;
        end
      end
      CPH_BUSY: begin
        if (link.ack) begin
          req_d = 1'b0;
          rdy_d = 1'b1;
          rv_d  = !init_q;
          rd_d  = link.rdata;
          st_d  = CPH_IDLE;
        end
      end
      default: begin
        st_d = CPH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q   <= CPH_INIT;
      req_q  <= 1'b0;
      we_q   <= 1'b0;
      addr_q <= 8'h00;
      wdat_q <= ZERO16;
      init_q <= 1'b0;
      rdy_q  <= 1'b0;
      rv_q   <= 1'b0;
      rd_q   <= ZERO16;
    end else begin
      st_q   <= st_d;
      req_q  <= req_d;
      we_q   <= we_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      init_q <= init_d;
      rdy_q  <= rdy_d;
      rv_q   <= rv_d;
      rd_q   <= rd_d;
    end
  end

  assign link.req    = req_q;
  assign link.we     = we_q;
  assign link.addr   = addr_q;
  assign link.wdata  = wdat_q;
  assign cmd_ready_o = rdy_q;
  assign rsp_valid_o = rv_q;
  assign rsp_data_o  = rd_q;
endmodule : cpe_host
`default_nettype wire

// ==== sim/cpe_link_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpe_link_properties
  import cpe_pkg::*;
(
  input wire logic        clk_i, // system clock
  input wire logic        rst_i, // async reset, high
  input wire logic        req,   // host request
  input wire logic        we,    // write strobe
  input wire logic [7:0]  addr,  // register index
  input wire logic [15:0] wdata, // write data
  input wire logic        ack,   // device answer
  input wire logic [15:0] rdata  // read data
);
  // ------------------------------------------------------------
  // shadow of calibration and config state
  // ------------------------------------------------------------
  logic [15:0] cal_d;
  logic [15:0] cal_q;
  logic        cfg_d;
  logic        cfg_q;

  // mirror acked writes so that reads can be predicted
  always_comb begin
    cal_d = cal_q;
    cfg_d = cfg_q;
    if (ack && we && addr == REG_CAL) begin
      cal_d = wdata;
    end
    if (ack && we && addr == REG_CONFIG) begin
      cfg_d = !wdata[CFG_RST_BIT];
      if (wdata[CFG_RST_BIT]) begin
        cal_d = ZERO16;
      end
    end
  end

  // power-up clears the shadow as it clears the device
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cal_q <= ZERO16;
      cfg_q <= 1'b0;
    end else begin
      cal_q <= cal_d;
      cfg_q <= cfg_d;
    end
  end

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_taken; req && !ack; endsequence
  sequence s_answer; ack ##1 (!ack && !req); endsequence
  sequence s_rd; ack && !we; endsequence

  property p_handshake; s_taken |=> s_answer; endproperty
  property p_hold; s_taken |=> req && $stable(addr) && $stable(we) && $stable(wdata); endproperty
  property p_cal_first; $past(rst_i) |-> ##[0:3] (req && we && addr == REG_CAL); endproperty
  property p_zero; s_rd ##0 ((addr == REG_POWER || addr == REG_CURRENT) && cal_q == ZERO16)
    |-> rdata == ZERO16; endproperty
  property p_cal_back; s_rd ##0 (addr == REG_CAL) |-> rdata == cal_q; endproperty
  property p_cfg_dflt; s_rd ##0 (addr == REG_CONFIG && !cfg_q) |-> rdata == CONFIG_RST; endproperty
  property p_bus_gap; s_rd ##0 (addr == REG_BUS) |-> rdata[2] == 1'b0; endproperty
  property p_unmapped; s_rd ##0 (addr > REG_CAL) |-> rdata == ZERO16; endproperty
  property p_rd_stands; $changed(rdata) |-> ack && !we; endproperty

  a_handshake: assert property (p_handshake) else $error("answer not one cycle after request");
  a_hold: assert property (p_hold) else $error("request changed before answer");
  a_cal_first: assert property (p_cal_first) else $error("no calibration write after reset");
  a_zero: assert property (p_zero) else $error("result nonzero without calibration");
  a_cal_back: assert property (p_cal_back) else $error("calibration readback wrong");
  a_cfg_dflt: assert property (p_cfg_dflt) else $error("config not at power-up value");
  a_bus_gap: assert property (p_bus_gap) else $error("bus word gap bit set");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  a_rd_stands: assert property (p_rd_stands) else $error("read data moved without read");
endmodule : cpe_link_properties
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cpe_pkg::*;
  logic clk_i, rst_i, meas_valid_i, cmd_valid_i, cmd_write_i, bus_range_o, flag, cmd_ready_o;
  logic rsp_valid_o, fl;
  logic [3:0] shunt_adc_o, bus_adc_o;
  logic [1:0] gain_o;
  logic [2:0] mode_o;
  logic [12:0] bus_raw_i, b;
  logic [7:0] cmd_addr_i;
  logic [15:0] shunt_raw_i, cal_i, cmd_wdata_i, rsp_data_o, current_o, power_o, rd, s, c, cfg;
  int miscompares, checks_done, seed;

  cpe_link_if cpe_link_if_inst ();
  cpe_device cpe_device_inst (.clk_i(clk_i), .rst_i(rst_i), .link(cpe_link_if_inst),
    .meas_valid_i(meas_valid_i), .shunt_raw_i(shunt_raw_i), .bus_raw_i(bus_raw_i),
    .shunt_adc_o(shunt_adc_o), .bus_adc_o(bus_adc_o), .shunt_gain_range_o(gain_o),
    .bus_range_o(bus_range_o), .mode_o(mode_o), .conversion_ready_flag_o(flag),
    .current_o(current_o), .power_o(power_o));
  cpe_host cpe_host_inst (.clk_i(clk_i), .rst_i(rst_i), .link(cpe_link_if_inst), .cal_i(cal_i),
    .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i), .cmd_addr_i(cmd_addr_i),
    .cmd_wdata_i(cmd_wdata_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o));
  cpe_link_properties cpe_link_properties_inst (.clk_i(clk_i), .rst_i(rst_i),
    .req(cpe_link_if_inst.req), .we(cpe_link_if_inst.we), .addr(cpe_link_if_inst.addr),
    .wdata(cpe_link_if_inst.wdata), .ack(cpe_link_if_inst.ack), .rdata(cpe_link_if_inst.rdata));

  // ------------------------------------------------------------
  // expectations and checking
  // ------------------------------------------------------------
  function automatic logic [15:0] sat(input longint v);
    if (v > 64'sh7FFF) return 16'h7FFF;
    if (v < -64'sh8000) return 16'h8000;
    return v[15:0];
  endfunction : sat
  // longint division truncates toward zero, as the results must
  function automatic logic [15:0] exp_cur(input logic [15:0] sv, cv);
    return sat(longint'($signed(sv)) * longint'(cv) / 4096);
  endfunction : exp_cur
  function automatic logic [15:0] exp_pwr(input logic [15:0] iv, input logic [12:0] bv);
    return sat(longint'($signed(iv)) * longint'(bv) / 5000);
  endfunction : exp_pwr
  // overflow status: either quotient left the 16-bit signed range
  function automatic logic exp_ovf(input logic [15:0] sv, cv, input logic [12:0] bv);
    longint cw, pw;
    cw = longint'($signed(sv)) * longint'(cv) / 4096;
    pw = longint'($signed(exp_cur(sv, cv))) * longint'(bv) / 5000;
    return (cw > 32767 || cw < -32768 || pw > 32767 || pw < -32768);
  endfunction : exp_ovf
  function automatic logic [15:0] pick(input logic [15:0] w);
    return {2'h0, w[6:3], w[10:7], w[12:11], w[13], w[2:0]};
  endfunction : pick
  function automatic logic [15:0] pins();
    return {2'h0, shunt_adc_o, bus_adc_o, gain_o, bus_range_o, mode_o};
  endfunction : pins

  task automatic check(input logic [15:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  // bounded wait on a level sampled just after the edge
  task automatic await(input int sel);
    int n;
    n = 0;
    while ((sel ? rsp_valid_o : cmd_ready_o) !== 1'b1) begin
      n++;
      if (n > 40) begin
        check(16'h0, 16'h1, "wait limit");
        print_verdict();
      end
      @(posedge clk_i);
      #2;
    end
  endtask : await

  // one host command, read data left in rd
  task automatic cmd(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    #2;
    cmd_valid_i = 1'b1;
    cmd_write_i = w;
    cmd_addr_i = a;
    cmd_wdata_i = d;
    await(0);
    @(posedge clk_i);
    #2;
    cmd_valid_i = 1'b0;
    await(1);
    rd = rsp_data_o;
  endtask : cmd

  // one measurement pair, results checked at their fixed latency
  task automatic meas(input logic [15:0] sv, input logic [12:0] bv, input logic [15:0] cv,
                      input logic fz);
    @(posedge clk_i);
    #2;
    meas_valid_i = 1'b1;
    shunt_raw_i = sv;
    bus_raw_i = bv;
    @(posedge clk_i);
    #2;
    meas_valid_i = 1'b0;
    shunt_raw_i = ~sv;  // scrambled so a late sample shows up
    bus_raw_i = ~bv;
    @(posedge clk_i);
    #2;
    @(posedge clk_i);
    #2;
    check(current_o, exp_cur(sv, cv), "current");
    if (fz) check({15'h0, flag}, 16'h0, "flag early");
    @(posedge clk_i);
    #2;
    check(power_o, exp_pwr(exp_cur(sv, cv), bv), "power");
    if (cv != 16'h0) check({15'h0, flag}, 16'h1, "flag set");
  endtask : meas

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'h0EFE5763;
    {meas_valid_i, cmd_valid_i, cmd_write_i, cmd_addr_i, cmd_wdata_i} = '0;
    {shunt_raw_i, bus_raw_i, cal_i} = '0;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #2;
    rst_i = 1'b0;
    cmd(0, REG_CONFIG, 16'h0);
    check(rd, CONFIG_RST, "config word");
    check(pins(), pick(CONFIG_RST), "config pins");
    $display("test defaults done");
    meas(16'h1234, 13'h0100, 16'h0, 0);
    cmd(0, REG_CURRENT, 16'h0);
    check(rd, 16'h0, "current unprogrammed");
    cmd(1, REG_POWER, 16'h5A5A);
    cmd(0, REG_POWER, 16'h0);
    check(rd, 16'h0, "power unprogrammed");
    cmd(0, 8'h07, 16'h0);
    $display("test unprogrammed done");
    for (int i = 0; i < 24; i++) begin
      case (i)
        0: {s, b, c} = {16'h8000, 13'h1FFF, 16'hFFFF};
        1: {s, b, c} = {16'h7FFF, 13'h1FFF, 16'hFFFF};
        2: {s, b, c} = {16'hFFFF, 13'h0001, 16'h0001};
        3: {s, b, c} = {16'hFF00, 13'h0FA0, 16'h1001};
        default: {s, b, c} = 45'({$random(seed), $random(seed)});
      endcase
      if (c == 16'h0) c = 16'h0001;
      cmd(1, REG_CAL, c);
      meas(s, b, c, 0);
    end
    $display("test scaling done");
    cmd(0, REG_BUS, 16'h0);
    check({3'h0, rd[15:3]}, {3'h0, b}, "bus field");
    check({15'h0, rd[1]}, 16'h1, "status ready");
    check({15'h0, rd[0]}, {15'h0, exp_ovf(s, c, b)}, "overflow flag");
    check({15'h0, flag}, 16'h0, "flag cleared");
    meas(s, b, c, 1);
    $display("test ready flag done");
    fl = 1'b1;
    for (int i = 0; i < 4; i++) begin
      cfg = 16'($random(seed)) & 16'h3FFF;
      cfg[10:7] = ~cfg[6:3];
      // first pass keeps the flag: adc-off write must not clear it
      if (i == 0) cfg[2:0] = MODE_ADCOFF;
      fl = fl & (cfg[2:0] == MODE_PDOWN || cfg[2:0] == MODE_ADCOFF);
      cmd(1, REG_CONFIG, cfg);
      check(pins(), pick(cfg), "config pins");
      check({15'h0, flag}, {15'h0, fl}, "flag on config");
      cmd(0, REG_CONFIG, 16'h0);
      check(rd, cfg, "config readback");
    end
    cmd(1, REG_CONFIG, 16'h8000);
    check(pins(), pick(CONFIG_RST), "config restore");
    cmd(0, REG_CURRENT, 16'h0);
    check(rd, 16'h0, "current after restore");
    $display("test config done");
    cal_i = 16'($random(seed)) | 16'h0001;
    @(posedge clk_i);
    #2;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #2;
    rst_i = 1'b0;
    cmd(0, REG_CAL, 16'h0);
    check(rd, cal_i, "calibration restored");
    cmd(0, REG_CONFIG, 16'h0);
    check(rd, CONFIG_RST, "config after reset");
    meas(16'hC350, 13'h0ABC, cal_i, 0);
    cmd(0, REG_SHUNT, 16'h0);
    check(rd, 16'hC350, "shunt word");
    $display("test second reset done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
